// File: cmmd_cfg.svh
// Constants for the processor memory-map decoder
// =====================================================================
// Overview of operation
// - At 33 MHz each external memory access takes exactly four bus clocks
// - External memory data path is either 8 or 16 bits wide
// - Synchronous or asynchronous memory, only one type configured at a time
// - External memory reached through external data space, up to 24 address bits
// - Code space is 64 KB and decodes only to main program flash
// - Lowest 32 RAM bytes are four register banks; next 16 bytes bit-addressable
// - Direct upper-128 accesses select SFRs; indirect ones select upper RAM
// - Stack uses indirect addressing, so it may span all 256 bytes
// - Pointer select picks one of two 16-bit pointers for pointer instructions
// - Pointer-based external move takes top address byte from matching extension
// - Register-based external move takes top byte upper ext, next byte page ext
// - Extension registers only affect external moves, nothing else
// - Ports 0-6, 12, 15 each offer fast out, pin state, source select
// - Set select bit drives pin from fast out; clear hands it to hub data
// - Pin state register is read-only and returns live pin levels
// - External data space is 24 bits; on-chip resources decode only in the lower half
// - Addresses from zero up to the 8 KB boundary decode to on-chip SRAM
// - Upper half of the 24-bit space routes to the external memory interface
// - A 256-byte window decodes to external memory interface control registers
// - A 4 KB window decodes to nonvolatile user memory
// - An 8 KB window decodes to the flash error-correction bytes
`ifndef CMMD_CFG_SVH
`define CMMD_CFG_SVH
// =====================================================================
// Timing
`define CMMD_XMEM_CYCLES 2'h3
// =====================================================================
// External data regions
`define CMMD_SRAM_LO 24'h000000
`define CMMD_SRAM_HI 24'h001FFF
`define CMMD_PORTS_LO 24'h005000
`define CMMD_PORTS_HI 24'h0051FF
`define CMMD_XMCTL_LO 24'h005400
`define CMMD_XMCTL_HI 24'h0054FF
`define CMMD_NVMEM_LO 24'h008000
`define CMMD_NVMEM_HI 24'h008FFF
`define CMMD_ECC_LO 24'h080000
`define CMMD_ECC_HI 24'h081FFF
`define CMMD_EXT_BIT 23
// =====================================================================
// Internal data layout
`define CMMD_WORKREG_TOP 8'h1F
`define CMMD_BITAREA_TOP 8'h2F
// =====================================================================
// SFR addresses
`define CMMD_SFR_PTR0_LO 8'h82
`define CMMD_SFR_PTR0_HI 8'h83
`define CMMD_SFR_PTR1_LO 8'h84
`define CMMD_SFR_PTR1_HI 8'h85
`define CMMD_SFR_PSEL 8'h86
`define CMMD_SFR_PX0 8'h93
`define CMMD_SFR_PX1 8'h95
`define CMMD_SFR_UPX 8'hEA
`define CMMD_SFR_PGX 8'hA0
`define CMMD_SFR_OUT_LIST {8'hF8, 8'hE8, 8'hD8, 8'hC8, 8'hC0, 8'hB0, 8'h98, 8'h90, 8'h80}
`define CMMD_SFR_PS_LIST {8'hF9, 8'hE9, 8'hD9, 8'hC9, 8'hC1, 8'hB1, 8'h99, 8'h91, 8'h89}
`define CMMD_SFR_SEL_LIST {8'hFA, 8'hF2, 8'hDA, 8'hCA, 8'hC2, 8'hB2, 8'h9A, 8'hA2, 8'h8A}
// =====================================================================
// Reset values
`define CMMD_RST_BYTE 8'h00
`define CMMD_RST_WORD 16'h0000
`endif

// File: cmmd_pkg.sv
// Types for the processor memory-map decoder
package cmmd_pkg;
   typedef enum logic [2:0] {
      CMMD_RG_NONE = 3'b000,
      CMMD_RG_SRAM = 3'b001,
      CMMD_RG_PORTS = 3'b010,
      CMMD_RG_XMCTL = 3'b011,
      CMMD_RG_NVMEM = 3'b100,
      CMMD_RG_ECC = 3'b101,
      CMMD_RG_EXT = 3'b110
   } cmmd_region_t;
   typedef enum logic [1:0] {
      CMMD_IDLE = 2'b00,
      CMMD_BUSY = 2'b01
   } cmmd_fsm_t;
   typedef struct packed {
      logic sel;
      logic wr;
      cmmd_region_t region;
      logic [23:0] addr;
      logic [7:0] wdata;
   } cmmd_xbus_t;
   typedef struct packed {
      logic cs;
      logic we;
      logic sync;
      logic wide;
      logic [23:0] addr;
      logic [1:0] be;
      logic [15:0] wdata;
   } cmmd_xmem_t;
   typedef struct packed {
      logic sel_sfr;
      logic sel_ram;
      logic work_reg;
      logic bit_area;
      logic [1:0] bank;
   } cmmd_idata_t;
   typedef struct packed {
      cmmd_fsm_t fsm;
      logic [1:0] cnt;
      logic done;
      logic hi_lane;
      logic [7:0] rdata;
      cmmd_xbus_t xbus;
      cmmd_xmem_t xmem;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
      logic [7:0] psel;
      logic [7:0] px0;
      logic [7:0] px1;
      logic [7:0] upx;
      logic [7:0] pgx;
      logic [8:0][7:0] fast_out;
      logic [8:0][7:0] src_sel;
      logic [8:0][7:0] pad_out;
      logic [7:0] sfr_rdata;
   } cmmd_state_t;
endpackage

// File: cmmd_decoder.sv
// Processor memory-map decoder with address extension and fast port SFRs
`timescale 1ns/1ps
`include "cmmd_cfg.svh"
module cmmd_decoder (
   input wire logic clk,
   input wire logic sys_rst,
   // Code fetch
   input wire logic code_fetch,
   input wire logic [15:0] code_addr,
   output logic code_flash_sel,
   output logic [15:0] code_flash_addr,
   // Internal data access
   input wire logic [7:0] ida_addr,
   input wire logic ida_indirect,
   input wire logic ida_stack,
   output cmmd_pkg::cmmd_idata_t ida_sel,
   // SFR access
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Pointer instructions
   input wire logic ptr_inc,
   input wire logic ptr_load,
   input wire logic [15:0] ptr_imm,
   output logic [15:0] active_ptr,
   // External moves
   input wire logic movx_valid,
   input wire logic movx_wr,
   input wire logic movx_use_ri,
   input wire logic [7:0] movx_ri,
   input wire logic [7:0] movx_wdata,
   output logic movx_ready,
   output logic [7:0] movx_rdata,
   // On-chip external-data bus
   output cmmd_pkg::cmmd_xbus_t xbus,
   input wire logic [7:0] xbus_rdata,
   // External memory interface
   input wire logic xmem_wide,
   input wire logic xmem_sync,
   output cmmd_pkg::cmmd_xmem_t xmem,
   input wire logic [15:0] xmem_rdata,
   // Fast ports
   input wire logic [8:0][7:0] pin_state,
   input wire logic [8:0][7:0] hub_port_data,
   output logic [8:0][7:0] pad_out
);
   localparam logic [8:0][7:0] OUT_ADDR = `CMMD_SFR_OUT_LIST;
   localparam logic [8:0][7:0] PS_ADDR = `CMMD_SFR_PS_LIST;
   localparam logic [8:0][7:0] SEL_ADDR = `CMMD_SFR_SEL_LIST;

   cmmd_pkg::cmmd_state_t s_q;
   cmmd_pkg::cmmd_state_t s_d;
   logic [23:0] mv_addr;
   logic [8:0][7:0] pad_mux;
   logic [15:0] cur_ptr;

   // =====================================================================
   // Decode helpers
   function automatic cmmd_pkg::cmmd_region_t region_of(input logic [23:0] a);
      cmmd_pkg::cmmd_region_t r;
      r = cmmd_pkg::CMMD_RG_NONE;
      if (a[`CMMD_EXT_BIT]) begin
         r = cmmd_pkg::CMMD_RG_EXT;
      end else if (a <= `CMMD_SRAM_HI) begin
         r = cmmd_pkg::CMMD_RG_SRAM;
      end else if (a >= `CMMD_PORTS_LO && a <= `CMMD_PORTS_HI) begin
         r = cmmd_pkg::CMMD_RG_PORTS;
      end else if (a >= `CMMD_XMCTL_LO && a <= `CMMD_XMCTL_HI) begin
         r = cmmd_pkg::CMMD_RG_XMCTL;
      end else if (a >= `CMMD_NVMEM_LO && a <= `CMMD_NVMEM_HI) begin
         r = cmmd_pkg::CMMD_RG_NVMEM;
      end else if (a >= `CMMD_ECC_LO && a <= `CMMD_ECC_HI) begin
         r = cmmd_pkg::CMMD_RG_ECC;
      end
      return r; // Everything else answers as empty space
   endfunction

   function automatic logic [3:0] port_hit(input logic [8:0][7:0] tbl, input logic [7:0] a);
      logic [3:0] idx;
      idx = 4'hF;
      for (int i = 0; i < 9; i++) begin
         if (tbl[i] == a) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   // =====================================================================
   // Code and internal data decode
   assign code_flash_sel = code_fetch;
   assign code_flash_addr = code_addr;

   always_comb begin
      ida_sel.work_reg = ida_addr <= `CMMD_WORKREG_TOP;
      ida_sel.bit_area = !ida_sel.work_reg && ida_addr <= `CMMD_BITAREA_TOP;
      ida_sel.bank = ida_addr[4:3];
      // Stack always goes indirect so it can use the full RAM
      ida_sel.sel_sfr = ida_addr[7] && !ida_indirect && !ida_stack;
      ida_sel.sel_ram = !ida_sel.sel_sfr;
   end

   // =====================================================================
   // Fast port pin mux
   generate
      for (genvar p = 0; p < 9; p++) begin : g_port
         for (genvar b = 0; b < 8; b++) begin : g_bit
            assign pad_mux[p][b] = s_q.src_sel[p][b] ? s_q.fast_out[p][b] : hub_port_data[p][b];
         end
      end
   endgenerate

   // Extension bytes only enter the external-move address
   assign cur_ptr = s_q.psel[0] ? s_q.ptr1 : s_q.ptr0;
   always_comb begin
      if (movx_use_ri) begin
         mv_addr = {s_q.upx, s_q.pgx, movx_ri};
      end else begin
         mv_addr = {(s_q.psel[0] ? s_q.px1 : s_q.px0), cur_ptr};
      end
   end

   // =====================================================================
   // Next state
   always_comb begin
      logic [3:0] oi;
      logic [3:0] pi;
      logic [3:0] si;
      cmmd_pkg::cmmd_region_t rg;
      oi = port_hit(OUT_ADDR, sfr_addr);
      pi = port_hit(PS_ADDR, sfr_addr);
      si = port_hit(SEL_ADDR, sfr_addr);
      rg = region_of(mv_addr);
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.pad_out = pad_mux;
      // SFR writes; pin state has no write path
      if (sfr_wr) begin
         if (oi != 4'hF) begin
            s_d.fast_out[oi] = sfr_wdata;
         end else if (si != 4'hF) begin
            s_d.src_sel[si] = sfr_wdata;
         end else if (sfr_addr == `CMMD_SFR_PTR0_LO) begin
            s_d.ptr0[7:0] = sfr_wdata;
         end else if (sfr_addr == `CMMD_SFR_PTR0_HI) begin
            s_d.ptr0[15:8] = sfr_wdata;
         end else if (sfr_addr == `CMMD_SFR_PTR1_LO) begin
            s_d.ptr1[7:0] = sfr_wdata;
         end else if (sfr_addr == `CMMD_SFR_PTR1_HI) begin
            s_d.ptr1[15:8] = sfr_wdata;
         end else if (sfr_addr == `CMMD_SFR_PSEL) begin
            s_d.psel = sfr_wdata;
         end else if (sfr_addr == `CMMD_SFR_PX0) begin
            s_d.px0 = sfr_wdata;
         end else if (sfr_addr == `CMMD_SFR_PX1) begin
            s_d.px1 = sfr_wdata;
         end else if (sfr_addr == `CMMD_SFR_UPX) begin
            s_d.upx = sfr_wdata;
         end else if (sfr_addr == `CMMD_SFR_PGX) begin
            s_d.pgx = sfr_wdata;
         end
      end
      // Pointer instructions win over a same-cycle SFR write
      if (ptr_load) begin
         if (s_q.psel[0]) begin
            s_d.ptr1 = ptr_imm;
         end else begin
            s_d.ptr0 = ptr_imm;
         end
      end else if (ptr_inc) begin
         if (s_q.psel[0]) begin
            s_d.ptr1 = s_q.ptr1 + 16'h0001;
         end else begin
            s_d.ptr0 = s_q.ptr0 + 16'h0001;
         end
      end
      // SFR reads
      if (sfr_rd) begin
         s_d.sfr_rdata = `CMMD_RST_BYTE;
         if (oi != 4'hF) begin
            s_d.sfr_rdata = s_q.fast_out[oi];
         end else if (pi != 4'hF) begin
            s_d.sfr_rdata = pin_state[pi];
         end else if (si != 4'hF) begin
            s_d.sfr_rdata = s_q.src_sel[si];
         end else if (sfr_addr == `CMMD_SFR_PTR0_LO) begin
            s_d.sfr_rdata = s_q.ptr0[7:0];
         end else if (sfr_addr == `CMMD_SFR_PTR0_HI) begin
            s_d.sfr_rdata = s_q.ptr0[15:8];
         end else if (sfr_addr == `CMMD_SFR_PTR1_LO) begin
            s_d.sfr_rdata = s_q.ptr1[7:0];
         end else if (sfr_addr == `CMMD_SFR_PTR1_HI) begin
            s_d.sfr_rdata = s_q.ptr1[15:8];
         end else if (sfr_addr == `CMMD_SFR_PSEL) begin
            s_d.sfr_rdata = s_q.psel;
         end else if (sfr_addr == `CMMD_SFR_PX0) begin
            s_d.sfr_rdata = s_q.px0;
         end else if (sfr_addr == `CMMD_SFR_PX1) begin
            s_d.sfr_rdata = s_q.px1;
         end else if (sfr_addr == `CMMD_SFR_UPX) begin
            s_d.sfr_rdata = s_q.upx;
         end else if (sfr_addr == `CMMD_SFR_PGX) begin
            s_d.sfr_rdata = s_q.pgx;
         end
      end
      // External move sequencer
      case (s_q.fsm)
         cmmd_pkg::CMMD_IDLE: begin
            // The done cycle blocks relaunch while the core drops its request
            if (movx_valid && !s_q.done) begin
               s_d.fsm = cmmd_pkg::CMMD_BUSY;
               s_d.xbus.addr = mv_addr;
               s_d.xbus.wr = movx_wr;
               s_d.xbus.wdata = movx_wdata;
               s_d.xbus.region = rg;
               if (rg == cmmd_pkg::CMMD_RG_EXT) begin
                  s_d.cnt = `CMMD_XMEM_CYCLES;
                  s_d.xmem.cs = 1'b1;
                  s_d.xmem.we = movx_wr;
                  // Type is latched per access; only one type is live
                  s_d.xmem.sync = xmem_sync;
                  s_d.xmem.wide = xmem_wide;
                  s_d.xmem.addr = xmem_wide ? {1'b0, mv_addr[23:1]} : mv_addr;
                  s_d.xmem.be = (xmem_wide && mv_addr[0]) ? 2'h2 : 2'h1;
                  s_d.xmem.wdata = {movx_wdata, movx_wdata};
                  s_d.hi_lane = xmem_wide && mv_addr[0];
               end else begin
                  s_d.cnt = 2'h0;
                  s_d.xbus.sel = rg != cmmd_pkg::CMMD_RG_NONE;
               end
            end
         end
         cmmd_pkg::CMMD_BUSY: begin
            s_d.xbus.sel = 1'b0;
            if (s_q.cnt == 2'h0) begin
               s_d.fsm = cmmd_pkg::CMMD_IDLE;
               s_d.done = 1'b1;
               s_d.xmem.cs = 1'b0;
               s_d.xmem.we = 1'b0;
               if (s_q.xbus.wr) begin
                  s_d.rdata = s_q.rdata;
               end else if (s_q.xbus.region == cmmd_pkg::CMMD_RG_EXT) begin
                  s_d.rdata = s_q.hi_lane ? xmem_rdata[15:8] : xmem_rdata[7:0];
               end else if (s_q.xbus.region == cmmd_pkg::CMMD_RG_NONE) begin
                  s_d.rdata = `CMMD_RST_BYTE;
               end else begin
                  s_d.rdata = xbus_rdata;
               end
            end else begin
               s_d.cnt = s_q.cnt - 2'h1;
            end
         end
         default: begin
            s_d.fsm = cmmd_pkg::CMMD_IDLE;
         end
      endcase
   end

   // =====================================================================
   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sfr_rdata = s_q.sfr_rdata;
   assign active_ptr = cur_ptr;
   assign movx_ready = s_q.done;
   assign movx_rdata = s_q.rdata;
   assign xbus = s_q.xbus;
   assign xmem = s_q.xmem;
   assign pad_out = s_q.pad_out;

   // =====================================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic launch;
   assign launch = s_q.fsm == cmmd_pkg::CMMD_IDLE && movx_valid && !s_q.done;

   sequence s_ext_launch;
      launch && region_of(mv_addr) == cmmd_pkg::CMMD_RG_EXT;
   endsequence
   sequence s_four_beats;
      xmem.cs [*4] ##1 !xmem.cs;
   endsequence

   a_ext_four_beats: assert property (s_ext_launch |=> s_four_beats)
      else $error("external access not four cycles");
   a_ext_ready_time: assert property (s_ext_launch |-> ##5 movx_ready)
      else $error("external access ready late");
   a_ptr_top_byte: assert property (launch && !movx_use_ri
      |=> xbus.addr[23:16] == $past(s_q.psel[0] ? s_q.px1 : s_q.px0))
      else $error("pointer move top byte wrong");
   a_ri_upper_bytes: assert property (launch && movx_use_ri
      |=> xbus.addr[23:8] == {$past(s_q.upx), $past(s_q.pgx)})
      else $error("register move upper bytes wrong");
   a_sram_low_region: assert property (launch && mv_addr <= `CMMD_SRAM_HI
      |=> xbus.sel && xbus.region == cmmd_pkg::CMMD_RG_SRAM)
      else $error("low space not sram");
   a_unmapped_zero: assert property (launch && !movx_wr && region_of(mv_addr) == cmmd_pkg::CMMD_RG_NONE
      |=> !xbus.sel ##1 movx_ready && movx_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_sfr_direct_upper: assert property (ida_addr[7] && !ida_indirect && !ida_stack
      |-> ida_sel.sel_sfr && !ida_sel.sel_ram)
      else $error("direct upper access not sfr");
   a_stack_ram_only: assert property (ida_stack |-> ida_sel.sel_ram)
      else $error("stack access left ram");
   a_pin_source_mux: assert property (!sys_rst |=> pad_out[0] ==
      (($past(s_q.src_sel[0]) & $past(s_q.fast_out[0])) | (~$past(s_q.src_sel[0]) & $past(hub_port_data[0]))))
      else $error("port pin source wrong");
   a_pin_state_live: assert property (sfr_rd && sfr_addr == PS_ADDR[8]
      |=> sfr_rdata == $past(pin_state[8]))
      else $error("pin state read not live");
   a_ptr_inc_select: assert property (ptr_inc && !ptr_load && s_q.psel[0]
      |=> s_q.ptr1 == $past(s_q.ptr1) + 16'h0001 && s_q.ptr0 == $past(s_q.ptr0))
      else $error("increment hit wrong pointer");
endmodule // cmmd_decoder

// File: cmmd_far_model.sv
// Far-side responder for the on-chip data bus and the external memory
`timescale 1ns/1ps
module cmmd_far_model (
   input wire logic clk,
   input cmmd_pkg::cmmd_xbus_t xbus,
   output logic [7:0] xbus_rdata,
   input cmmd_pkg::cmmd_xmem_t xmem,
   output logic [15:0] xmem_rdata
);
   // =====================================================================
   // Response
   // Idle lines show the inverse of the last value, so stale data never matches
   logic [7:0] xb_last_q = 8'h00;
   logic [15:0] xm_last_q = 16'h0000;
   always_comb begin
      xbus_rdata = xbus.sel ? (xbus.addr[7:0] ^ 8'hA5) : ~xb_last_q;
      xmem_rdata = xmem.cs ? {xmem.addr[7:0] ^ 8'h3C, xmem.addr[7:0] ^ 8'hC3} : ~xm_last_q;
   end
   always_ff @(posedge clk) begin
      xb_last_q <= xbus_rdata;
      xm_last_q <= xmem_rdata;
   end
endmodule // cmmd_far_model

// File: test_cpu_memory_map_decoder.sv
// Self-checking bench for the processor memory-map decoder
`timescale 1ns/1ps
`include "cmmd_cfg.svh"
module test_cpu_memory_map_decoder;
   logic clk, sys_rst, code_fetch, ida_indirect, ida_stack, sfr_wr, sfr_rd, ptr_inc, ptr_load, ext;
   logic movx_valid, movx_wr, movx_use_ri, movx_ready, xmem_wide, xmem_sync, code_flash_sel;
   logic [15:0] code_addr, code_flash_addr, ptr_imm, active_ptr, xmem_rdata;
   logic [7:0] ida_addr, sfr_addr, sfr_wdata, sfr_rdata, movx_ri, movx_wdata, movx_rdata, xbus_rdata, rd;
   logic [8:0][7:0] pin_state, hub_port_data, pad_out, outs, pss, sels;
   cmmd_pkg::cmmd_idata_t ida_sel;
   cmmd_pkg::cmmd_xbus_t xbus, cap_x;
   cmmd_pkg::cmmd_xmem_t xmem, cap_m;
   int fail_count = 0;
   int cmp_count = 0;
   int lat, n_sel, n_cs;
   typedef struct packed {
      logic wr;
      logic [23:0] addr;
      logic [2:0] rg;
   } cmmd_tb_row_t;
   cmmd_tb_row_t rows [15] = '{
      '{1'b0, 24'h001FFF, 3'h1}, '{1'b1, 24'h000000, 3'h1}, '{1'b0, 24'h002000, 3'h0}, '{1'b0, 24'h005000, 3'h2},
      '{1'b1, 24'h0051FF, 3'h2}, '{1'b0, 24'h005200, 3'h0}, '{1'b0, 24'h005400, 3'h3}, '{1'b0, 24'h0054FF, 3'h3},
      '{1'b0, 24'h008FFF, 3'h4}, '{1'b0, 24'h080000, 3'h5}, '{1'b1, 24'h081FFF, 3'h5}, '{1'b0, 24'h082000, 3'h0},
      '{1'b1, 24'h7FFFFF, 3'h0}, '{1'b0, 24'h800000, 3'h6}, '{1'b1, 24'hFFFFFF, 3'h6}};
   // Indirect flag, stack flag, address, expected selection
   logic [15:0] irows [6] = '{{2'b00, 8'h9F, 6'b100011}, {2'b10, 8'h9F, 6'b010011}, {2'b01, 8'hFF, 6'b010011},
      {2'b00, 8'h1A, 6'b011011}, {2'b00, 8'h2F, 6'b010101}, {2'b00, 8'h30, 6'b010010}};

   cmmd_decoder u_dut (.clk, .sys_rst, .code_fetch, .code_addr, .code_flash_sel, .code_flash_addr, .ida_addr,
      .ida_indirect, .ida_stack, .ida_sel, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .ptr_inc, .ptr_load,
      .ptr_imm, .active_ptr, .movx_valid, .movx_wr, .movx_use_ri, .movx_ri, .movx_wdata, .movx_ready, .movx_rdata,
      .xbus, .xbus_rdata, .xmem_wide, .xmem_sync, .xmem, .xmem_rdata, .pin_state, .hub_port_data, .pad_out);
   cmmd_far_model u_far (.clk, .xbus, .xbus_rdata, .xmem, .xmem_rdata);

   // =====================================================================
   // Helpers
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [71:0] seen, input logic [71:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Tasks start and end on a rising edge; the idle edge avoids double drives
   task automatic sfr_put(input logic [7:0] a, input logic [7:0] d);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
      sfr_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic sfr_get(input logic [7:0] a);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1 rd = sfr_rdata;
      @(posedge clk);
   endtask
   task automatic movx(input logic wr, input logic ri_form, input logic [7:0] ri);
      movx_valid <= 1'b1;
      movx_wr <= wr;
      movx_use_ri <= ri_form;
      movx_ri <= ri;
      movx_wdata <= 8'h3A;
      lat = 0;
      n_sel = 0;
      n_cs = 0;
      do begin
         @(posedge clk);
         #1 lat++;
         if (xbus.sel === 1'b1) begin
            n_sel++;
            cap_x = xbus;
         end
         if (xmem.cs === 1'b1) begin
            n_cs++;
            cap_m = xmem;
         end
      end while (movx_ready !== 1'b1 && lat < 20);
      @(posedge clk);
      movx_valid <= 1'b0;
      @(posedge clk);
   endtask

   // =====================================================================
   // Main sequence
   initial begin
      {sys_rst, code_fetch, ida_indirect, ida_stack, sfr_wr, sfr_rd, ptr_inc, ptr_load} = 8'h80;
      {movx_valid, movx_wr, movx_use_ri, xmem_wide, xmem_sync} = 5'h00;
      {code_addr, ptr_imm, ida_addr, sfr_addr, sfr_wdata, movx_ri, movx_wdata} = 72'h0;
      pin_state = 72'hC3A55A3C96699F0F18;
      hub_port_data = 72'h0123456789ABCDEF77;
      outs = `CMMD_SFR_OUT_LIST;
      pss = `CMMD_SFR_PS_LIST;
      sels = `CMMD_SFR_SEL_LIST;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1 check(pad_out, hub_port_data, "pads after reset");
      @(posedge clk);
      foreach (rows[i]) begin
         sfr_put(`CMMD_SFR_UPX, rows[i].addr[23:16]);
         sfr_put(`CMMD_SFR_PGX, rows[i].addr[15:8]);
         movx(rows[i].wr, 1'b1, rows[i].addr[7:0]);
         ext = rows[i].rg == 3'h6;
         check(lat, ext ? 5 : 2, "move latency");
         check(n_cs, ext ? 4 : 0, "memory strobe count");
         if (ext) begin
            check(cap_m.addr, rows[i].addr, "memory address");
            check(cap_m.we, rows[i].wr, "memory direction");
            check({cap_m.be, cap_m.sync, cap_m.wide}, 4'h4, "narrow byte lane");
            if (rows[i].wr) check(cap_m.wdata, 16'h3A3A, "memory data");
            else check(movx_rdata, rows[i].addr[7:0] ^ 8'hC3, "memory read");
         end else if (rows[i].rg == 3'h0) begin
            check(n_sel, 0, "unmapped strobe count");
            if (!rows[i].wr) check(movx_rdata, 8'h00, "unmapped read");
         end else begin
            check(n_sel, 1, "bus strobe count");
            check(cap_x.region, rows[i].rg, "region");
            check(cap_x.addr, rows[i].addr, "bus address");
            check(cap_x.wr, rows[i].wr, "bus direction");
            if (rows[i].wr) check(cap_x.wdata, 8'h3A, "bus data");
            if (!rows[i].wr) check(movx_rdata, rows[i].addr[7:0] ^ 8'hA5, "bus read");
         end
      end
      $display("test address map done");
      foreach (irows[i]) begin
         {ida_indirect, ida_stack, ida_addr} <= irows[i][15:6];
         code_fetch <= 1'b1;
         code_addr <= {irows[i][13:6], 8'hFF};
         @(posedge clk);
         #1 check(ida_sel, irows[i][5:0], "internal data select");
         check({code_flash_sel, code_flash_addr}, {1'b1, irows[i][13:6], 8'hFF}, "code fetch");
         @(posedge clk);
      end
      $display("test internal spaces done");
      sfr_put(`CMMD_SFR_PTR0_LO, 8'h34);
      sfr_put(`CMMD_SFR_PTR0_HI, 8'h12);
      sfr_put(`CMMD_SFR_PTR1_LO, 8'hCD);
      sfr_put(`CMMD_SFR_PTR1_HI, 8'hAB);
      sfr_put(`CMMD_SFR_PX0, 8'h08);
      sfr_put(`CMMD_SFR_PX1, 8'h80);
      check(active_ptr, 16'h1234, "first pointer");
      movx(1'b0, 1'b0, 8'h00);
      check(cap_x.addr, 24'h081234, "first pointer move");
      sfr_put(`CMMD_SFR_PSEL, 8'h01);
      check(active_ptr, 16'hABCD, "second pointer");
      xmem_wide <= 1'b1;
      xmem_sync <= 1'b1;
      movx(1'b0, 1'b0, 8'h00);
      check(cap_m.addr, 24'h4055E6, "wide address");
      check({cap_m.be, cap_m.sync, cap_m.wide}, 4'hB, "odd byte lane");
      check(movx_rdata, 8'hDA, "odd byte read");
      ptr_inc <= 1'b1;
      @(posedge clk);
      ptr_inc <= 1'b0;
      #1 check(active_ptr, 16'hABCE, "pointer step");
      @(posedge clk);
      ptr_load <= 1'b1;
      ptr_imm <= 16'h5410;
      @(posedge clk);
      ptr_load <= 1'b0;
      #1 check(active_ptr, 16'h5410, "pointer load");
      @(posedge clk);
      $display("test pointers done");
      for (int p = 0; p < 9; p++) begin
         sfr_put(sels[p], 8'h0F);
         sfr_put(outs[p], 8'h50 + 8'(p));
         sfr_put(pss[p], 8'hFF);
         sfr_get(sels[p]);
         check(rd, 8'h0F, "select readback");
         sfr_get(outs[p]);
         check(rd, 8'h50 + 8'(p), "output readback");
         sfr_get(pss[p]);
         check(rd, pin_state[p], "pin state");
         check(pad_out[p], ((8'h50 + 8'(p)) & 8'h0F) | (hub_port_data[p] & 8'hF0), "pad mix");
      end
      pin_state <= ~pin_state;
      sfr_get(pss[7]);
      check(rd, pin_state[7], "live pin state");
      sfr_get(8'hBB);
      check(rd, 8'h00, "unmapped register");
      $display("test fast ports done");
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1 check(pad_out, hub_port_data, "pads after second reset");
      @(posedge clk);
      sfr_get(`CMMD_SFR_PSEL);
      check(rd, 8'h00, "select after reset");
      sfr_get(`CMMD_SFR_UPX);
      check(rd, 8'h00, "extension after reset");
      $display("test second reset done");
      stop_test();
   end
   // Whole run is well under 2000 cycles; this bound only catches a hang
   initial begin
      #400000;
      fail_count++;
      stop_test();
   end
endmodule // test_cpu_memory_map_decoder
